// ==== core/gpc_pkg.sv ====
// Constants and register map for the global pin control block
// Functional notes
// - Up to 32 digital pins can be handed to central control, one bit position per pin.
// - Supply, ground, analog inputs and the reset pin never come under this block.
// - Each shared pin can also be used as general purpose through its owning peripheral.
// - Pins outside the central set are configured only by their own local registers.
// - Ownership bit 0 gives the pin to its peripheral, 1 gives it to the central registers.
// - The ownership register is 32 bits, read/write over bits 31:0, reset to all zeros.
// - Five central per-pin registers: ownership, output enable, open drain, value, readback.
// - For a centrally owned pin the output enable bit selects input or output.
// - Reading the readback register returns the current level of each input pin; the code returns every pin's level after two sync flops (pin_s2).
// - An output pin is driven to the level of its output value bit.
// - The open drain bit chooses active high drive or release to an external pull-up.
package gpc_pkg;

	localparam int          PIN_COUNT = 32;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_OWN   = 12'h000;
	localparam logic [11:0] OFS_OE    = 12'h004;
	localparam logic [11:0] OFS_OD    = 12'h008;
	localparam logic [11:0] OFS_VAL   = 12'h00C;
	localparam logic [11:0] OFS_READ  = 12'h010;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] RST_OWN   = 32'h0000_0000;
	localparam logic [31:0] RST_OE    = 32'h0000_0000;
	localparam logic [31:0] RST_OD    = 32'h0000_0000;
	localparam logic [31:0] RST_VAL   = 32'h0000_0000;
	// Pins are released during reset; one clock later each follows its peripheral's per_oen, since ownership resets to the peripherals
	localparam logic [31:0] RST_PAD_OEN = 32'hFFFF_FFFF;

	// ----------------------------------------
	// AHB encodings
	// ----------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

	typedef struct packed {
		logic [31:0] own;
		logic [31:0] oe;
		logic [31:0] od;
		logic [31:0] val;
		logic [31:0] pin_s1;
		logic [31:0] pin_s2;
		logic        wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic [31:0] pad_out;
		logic [31:0] pad_oen;
		logic [31:0] per_in;
		logic        ready;
		logic        resp;
	} gpc_state_type;

endpackage

// ==== core/gpc_top.sv ====
// Global pin control: AHB-Lite register slave and per-pin drive mux
`timescale 1ns/1ps
module gpc_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [31:0] per_out,
	input  wire logic [31:0] per_oen,
	output logic      [31:0] per_in,
	input  wire logic [31:0] pad_in,
	output logic      [31:0] pad_out,
	output logic      [31:0] pad_oen
);

	gpc_pkg::gpc_state_type s_q;
	gpc_pkg::gpc_state_type s_d;

	logic        rd_go;
	logic        wr_go;
	logic [11:0] a_lo;
	logic [31:0] drv_oen;
	logic [31:0] drv_out;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		// Slave never stalls and always answers OKAY
		s_d.ready = 1'b1;
		s_d.resp  = 1'b0;
		a_lo = haddr[11:0];
		rd_go = hsel && hready && htrans[1] && !hwrite;
		wr_go = hsel && hready && htrans[1] && hwrite;

		// Pins pass two flops before anyone reads them
		s_d.pin_s1 = pad_in;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.per_in = s_q.pin_s2;

		// Write data arrives one phase after its address
		s_d.wr_pend = wr_go;
		if (wr_go) begin
			s_d.wr_addr = a_lo;
		end
		if (s_q.wr_pend) begin
			case (s_q.wr_addr)
				gpc_pkg::OFS_OWN: s_d.own = hwdata;
				gpc_pkg::OFS_OE:  s_d.oe  = hwdata;
				gpc_pkg::OFS_OD:  s_d.od  = hwdata;
				gpc_pkg::OFS_VAL: s_d.val = hwdata;
				default:          s_d.own = s_q.own;
			endcase
		end

		if (rd_go) begin
			case (a_lo)
				gpc_pkg::OFS_OWN:  s_d.rdata = s_q.own;
				gpc_pkg::OFS_OE:   s_d.rdata = s_q.oe;
				gpc_pkg::OFS_OD:   s_d.rdata = s_q.od;
				gpc_pkg::OFS_VAL:  s_d.rdata = s_q.val;
				gpc_pkg::OFS_READ: s_d.rdata = s_q.pin_s2;
				default:           s_d.rdata = 32'h0000_0000;
			endcase
		end

		// Central drive: open drain only pulls low, high is released
		for (int i = 0; i < gpc_pkg::PIN_COUNT; i++) begin
			drv_out[i] = s_q.val[i];
			drv_oen[i] = !s_q.oe[i] ||
				(s_q.od[i] && s_q.val[i]);
		end

		// Ownership mux; peripheral keeps the pin while its bit is clear.
		// Only mapped digital pins have a slot; power, analog and reset pins never do
		for (int i = 0; i < gpc_pkg::PIN_COUNT; i++) begin
			if (s_q.own[i]) begin
				s_d.pad_out[i] = drv_out[i];
				s_d.pad_oen[i] = drv_oen[i];
			end else begin
				s_d.pad_out[i] = per_out[i];
				s_d.pad_oen[i] = per_oen[i];
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q         <= '0;
			s_q.own     <= gpc_pkg::RST_OWN;
			s_q.oe      <= gpc_pkg::RST_OE;
			s_q.od      <= gpc_pkg::RST_OD;
			s_q.val     <= gpc_pkg::RST_VAL;
			s_q.pad_oen <= gpc_pkg::RST_PAD_OEN;
			s_q.ready   <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata    = s_q.rdata;
	assign hreadyout = s_q.ready;
	assign hresp     = s_q.resp;
	assign pad_out   = s_q.pad_out;
	assign pad_oen   = s_q.pad_oen;
	assign per_in    = s_q.per_in;

endmodule

// ==== sim/global_pin_io_control_test.sv ====
// Register and pin tests for the global pin control block
`timescale 1ns/1ps
module global_pin_io_control_test;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = '0, hwdata = '0, per_out = '0, per_oen = '1, ext_oen = '1, ext_val = '0, r;
	wire logic [31:0] hrdata, per_in, pad_in, pad_out, pad_oen;
	wire logic        hready, hreadyout, hresp;
	int          mismatches = 0, n_compared = 0, cyc = 0;
	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;
	gpc_top u_gpc_top (.*);
	gpc_board u_gpc_board (.*);
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Whole run needs well under 200 cycles
	always @(posedge hclk) if (++cyc == 1000) begin
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, gpc_pkg::OFS_OWN, '0); chk("own", 32'h0000_0000, r);
		bus(0, 12'h014, '0); chk("hole", 32'h0000_0000, r);
		per_out <= 32'hA5A5_5A5A;
		per_oen <= 32'h0000_FFFF;
		repeat (3) @(posedge hclk);
		chk("out", 32'hA5A5_5A5A, pad_out);
		chk("oen", 32'h0000_FFFF, pad_oen);
		bus(1, gpc_pkg::OFS_OE, '1);
		bus(1, gpc_pkg::OFS_VAL, 32'h3C3C_C3C3);
		bus(1, gpc_pkg::OFS_OWN, '1);
		bus(0, gpc_pkg::OFS_OWN, '0); chk("own", 32'hFFFF_FFFF, r);
		chk("out", 32'h3C3C_C3C3, pad_out);
		chk("oen", 32'h0000_0000, pad_oen);
		bus(1, gpc_pkg::OFS_OD, '1);
		repeat (4) @(posedge hclk);
		chk("oen", 32'h3C3C_C3C3, pad_oen);
		bus(0, gpc_pkg::OFS_READ, '0); chk("read", 32'h3C3C_C3C3, r);
		bus(1, gpc_pkg::OFS_OE, '0);
		ext_oen <= '0;
		ext_val <= 32'h96E1_1E69;
		repeat (4) @(posedge hclk);
		chk("oen", 32'hFFFF_FFFF, pad_oen);
		bus(0, gpc_pkg::OFS_READ, '0); chk("read", 32'h96E1_1E69, r);
		bus(1, gpc_pkg::OFS_OWN, '0);
		repeat (4) @(posedge hclk);
		chk("out", 32'hA5A5_5A5A, pad_out);
		chk("oen", 32'h0000_FFFF, pad_oen);
		bus(0, gpc_pkg::OFS_READ, '0); chk("read", 32'hA5A5_1E69, r);
		chk("per_in", 32'hA5A5_1E69, per_in);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, gpc_pkg::OFS_VAL, '0); chk("val", 32'h0000_0000, r);
		report_and_stop();
	end
endmodule

// ==== sim/gpc_asserts.sv ====
// Port checker for the global pin control block
`timescale 1ns/1ps
module gpc_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] per_out,
	input wire logic [31:0] per_oen,
	input wire logic [31:0] per_in,
	input wire logic [31:0] pad_in,
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oen
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Until the first write the peripherals must own every pin
	logic wr_seen_q;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) wr_seen_q <= 1'b0;
		else if (hsel && hready && htrans[1] && hwrite) wr_seen_q <= 1'b1;
	// Read address phase as the slave takes it
	logic rd_take;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	a_zero_wait: assert property (hreadyout) else $error("wait state");
	a_okay_resp: assert property (!hresp) else $error("bad response");
	a_sync_depth: assert property ($past(hresetn, 3) && $past(hresetn, 2) && $past(hresetn)
		|-> per_in == $past(pad_in, 3)) else $error("pin sync depth");
	a_pass_oen: assert property (!wr_seen_q && $past(hresetn) |-> pad_oen == $past(per_oen))
		else $error("enable passthrough");
	a_pass_out: assert property (!wr_seen_q && $past(hresetn) |-> pad_out == $past(per_out))
		else $error("level passthrough");
	a_rd_hold: assert property ($past(hresetn) && !$past(rd_take) |-> $stable(hrdata))
		else $error("read data moved");
	a_rst_clear: assert property ($rose(hresetn) |-> hrdata == 32'h0000_0000)
		else $error("read data after reset");
	a_rst_release: assert property ($rose(hresetn) |-> &pad_oen) else $error("pins driven");
endmodule
bind gpc_top gpc_checker u_gpc_checker (.*);

// ==== sim/gpc_board.sv ====
// Pin-side model: external pull-ups and an optional outside driver
`timescale 1ns/1ps
module gpc_board (
	input  wire logic [31:0] pad_out,
	input  wire logic [31:0] pad_oen,
	input  wire logic [31:0] ext_oen,
	input  wire logic [31:0] ext_val,
	output logic      [31:0] pad_in
);
	// Released pins float up; the block wins any overlap so a wire never goes unknown
	always_comb
		for (int i = 0; i < 32; i++)
			pad_in[i] = !pad_oen[i] ? pad_out[i] : (!ext_oen[i] ? ext_val[i] : 1'b1);
endmodule
